// ===== branch_sysctl_blockmove_exec.v
// Execution unit for branches, jumps, calls, returns, sleep, flag ops and block moves.
// Instructions are issued over APB; pclk 10 MHz, presetn asynchronous active low.
//
// Summary of operation
// [RULE_01] A conditional branch is taken when its 4-bit condition on C, Z, V and N holds.
// [RULE_02] An unconditional jump loads the program counter with the target regardless of flags.
// [RULE_03] A relative call pushes the return address and jumps to next address plus displacement.
// [RULE_04] Exception return pops the saved flags and program counter and resumes there.
// [RULE_05] Sleep requests power-down and halts issue until a wake condition arrives.
// [RULE_06] Flags load writes an immediate byte or a general register low byte into the flags.
// [RULE_07] Flags store copies the whole flags byte into the named general register.
// [RULE_08] Flags AND replaces the flags with their AND against the immediate byte.
// [RULE_09] Flags OR replaces the flags with their OR against the immediate byte.
// [RULE_10] Flags XOR replaces the flags with their XOR against the immediate byte.
// [RULE_11] No operation only advances the program counter by two.
// [RULE_12] Block move takes its byte count, source and destination from fixed general registers.
// [RULE_13] Block move copies a byte, bumps both pointers and counts down until zero; zero moves none.
// [RULE_14] No further instruction is accepted until the block move has finished.
// [RULE_15] Software keeps the destination from passing the top of the address space.
// [RULE_16] Untaken branches fall through to the next instruction without touching the flags.
// [RULE_17] Interrupt entry pushes program counter and flags at the stack pointer register.
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.vh"

module branch_sysctl_blockmove_exec (
  input  wire                pclk,
  input  wire                presetn,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [`APB_AW-1:0]  paddr,
  input  wire [31:0]         pwdata,
  input  wire                wake_req,
  output reg  [31:0]         prdata,
  output reg                 pready,
  output reg                 pslverr,
  output reg                 sleep_req,
  output reg                 exec_busy
);

  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_EXEC  = 3'd1;
  localparam [2:0] ST_PUSH  = 3'd2;
  localparam [2:0] ST_POP   = 3'd3;
  localparam [2:0] ST_MVRD  = 3'd4;
  localparam [2:0] ST_MVWR  = 3'd5;
  localparam [2:0] ST_SLEEP = 3'd6;

  reg  [2:0]              state_r;
  reg  [2:0]              st_nxt;
  reg  [3:0]              op_r;
  reg  [3:0]              cc_r;
  reg  [7:0]              imm_r;
  reg  [2:0]              ridx_r;
  reg                     ldc_reg_r;
  reg  [15:0]             tgt_r;
  reg  [15:0]             pc_r;
  reg  [7:0]              ccr_r;
  reg  [15:0]             ret_r;
  reg  [15:0]             newpc_r;
  reg  [1:0]              step_r;
  reg                     pop_ph_r;
  reg  [31:0]             pop_buf_r;
  reg                     taken_r;
  reg  [`MEM_AW-1:0]      mem_addr_r;
  reg  [`MEM_AW-1:0]      mem_addr;
  reg                     mem_we;
  reg  [7:0]              mem_wd;
  reg                     gw_en;
  reg  [2:0]              gw_sel;
  reg  [15:0]             gw_data;
  reg                     sp_we;
  reg  [15:0]             sp_nxt;
  reg                     mv_step;
  reg  [31:0]             rd_data;
  wire [7:0]              mem_rdata;
  wire [16*`GR_NUM-1:0]   gr_bus;

  function gr_hit;
    input [`APB_AW-1:0] a;
    begin
      gr_hit = (a[`A_GRWIN] == `GRWIN_VAL) && (a[`A_ALIGN] == 2'b00);
    end
  endfunction

  function reg_mapped;
    input [`APB_AW-1:0] a;
    begin
      reg_mapped = gr_hit(a) || a == `A_INSTR || a == `A_TARGET || a == `A_PC ||
                   a == `A_CCR || a == `A_STATUS || a == `A_MEMADDR || a == `A_MEMDATA;
    end
  endfunction

  function cond_true;
    input [3:0] cc;
    input [7:0] f;
    reg base;
    begin
      base = 1'b1;
      case (cc[3:1])
        3'd0:    base = 1'b1;
        3'd1:    base = ~(f[`CCR_C] | f[`CCR_Z]);
        3'd2:    base = ~f[`CCR_C];
        3'd3:    base = ~f[`CCR_Z];
        3'd4:    base = ~f[`CCR_V];
        3'd5:    base = ~f[`CCR_N];
        3'd6:    base = ~(f[`CCR_N] ^ f[`CCR_V]);
        3'd7:    base = ~(f[`CCR_Z] | (f[`CCR_N] ^ f[`CCR_V]));
        default: base = 1'b1;
      endcase
      // Odd codes are the inverse of the even code below them
      cond_true = base ^ cc[0];
    end
  endfunction

  // Frame of four bytes: flags, flags, PC high, PC low; two-byte frame: PC only
  function [7:0] frame_byte;
    input [1:0]  step;
    input        four;
    input [15:0] ret;
    input [7:0]  f;
    begin
      if (four) begin
        frame_byte = (step[1] == 1'b0) ? f : (step[0] ? ret[7:0] : ret[15:8]);
      end else begin
        frame_byte = step[0] ? ret[7:0] : ret[15:8];
      end
    end
  endfunction

  wire        apb_acc = psel & penable;
  wire        wr_ev   = apb_acc & pready & pwrite;
  wire        idle    = (state_r == ST_IDLE);
  wire        issue   = wr_ev & idle & (paddr == `A_INSTR);
  wire        wake    = wake_req | (wr_ev & (paddr == `A_STATUS) & pwdata[`ST_WAKE]);
  wire        four    = (op_r == `OP_IRQ) || (op_r == `OP_RTE);
  wire [15:0] flen    = four ? `FRAME_LEN4 : `FRAME_LEN2;
  wire [1:0]  slast   = four ? `STEP_LAST4 : `STEP_LAST2;
  wire [15:0] sp      = gr_bus[`GR_SP*16 +: 16];
  wire [15:0] src     = gr_bus[`GR_SRC*16 +: 16];
  wire [15:0] dst     = gr_bus[`GR_DST*16 +: 16];
  wire [7:0]  cnt     = gr_bus[`GR_CNT*16 +: 8];
  wire [15:0] sel_gr  = gr_bus[ridx_r*16 +: 16];
  wire [15:0] nxt_pc  = pc_r + `PC_STEP;
  wire [15:0] sp_step = sp + {14'h0000, step_r};
  wire [31:0] pop_w   = {pop_buf_r[23:0], mem_rdata};
  // Writes other than to the status register are refused while an instruction is in flight
  wire        refuse  = ~reg_mapped(paddr) | (pwrite & ~idle & (paddr != `A_STATUS));

  exec_byte_ram u_ram (
    .clk   (pclk),
    .addr  (mem_addr),
    .we    (mem_we),
    .wdata (mem_wd),
    .rdata (mem_rdata)
  );

  genvar g;
  generate
    for (g = 0; g < `GR_NUM; g = g + 1) begin : gr_gen
      reg [15:0] gr_r;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          gr_r <= `GR_RST;
        end else if (mv_step && g == `GR_CNT) begin
          gr_r <= {gr_r[15:8], gr_r[7:0] - `CNT_STEP}; // [RULE_13]
        end else if (mv_step && (g == `GR_SRC || g == `GR_DST)) begin
          gr_r <= gr_r + `PTR_STEP; // [RULE_13]
        end else if (sp_we && g == `GR_SP) begin
          gr_r <= sp_nxt; // [RULE_17]
        end else if (gw_en && gw_sel == g) begin
          gr_r <= gw_data;
        end
      end
      assign gr_bus[16*g +: 16] = gr_r;
    end
  endgenerate

  always @* begin
    case (paddr)
      `A_INSTR:   rd_data = {12'h000, ldc_reg_r, ridx_r, imm_r, cc_r, op_r};
      `A_TARGET:  rd_data = {16'h0000, tgt_r};
      `A_PC:      rd_data = {16'h0000, pc_r};
      `A_CCR:     rd_data = {24'h000000, ccr_r};
      `A_STATUS:  rd_data = {29'h00000000, taken_r, sleep_req, exec_busy};
      `A_MEMADDR: rd_data = {24'h000000, mem_addr_r};
      `A_MEMDATA: rd_data = {24'h000000, mem_rdata};
      default:    rd_data = gr_hit(paddr) ?
                            {16'h0000, gr_bus[paddr[`A_GRIDX]*16 +: 16]} : 32'h00000000;
    endcase
  end

  always @* begin
    st_nxt  = state_r;
    mem_addr = mem_addr_r;
    mem_we  = 1'b0;
    mem_wd  = pwdata[7:0];
    gw_en   = 1'b0;
    gw_sel  = paddr[`A_GRIDX];
    gw_data = pwdata[15:0];
    sp_we   = 1'b0;
    sp_nxt  = sp;
    mv_step = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (issue) begin
          st_nxt = ST_EXEC;
        end
        mem_we = wr_ev & (paddr == `A_MEMDATA);
        gw_en  = wr_ev & gr_hit(paddr);
      end
      ST_EXEC: begin
        st_nxt = ST_IDLE;
        case (op_r)
          `OP_JSR, `OP_BSR, `OP_IRQ: begin
            st_nxt = ST_PUSH;
            sp_we  = 1'b1;
            sp_nxt = sp - flen; // [RULE_17]
          end
          `OP_RTE, `OP_RTS: st_nxt = ST_POP;
          `OP_SLEEP:        st_nxt = ST_SLEEP;
          `OP_MOVE:         st_nxt = (cnt == `CNT_ZERO) ? ST_IDLE : ST_MVRD; // [RULE_13]
          `OP_STC: begin
            gw_en   = 1'b1;
            gw_sel  = ridx_r;
            gw_data = {sel_gr[15:8], ccr_r}; // [RULE_07]
          end
          default: st_nxt = ST_IDLE;
        endcase
      end
      ST_PUSH: begin
        mem_addr = sp_step[`MEM_AW-1:0];
        mem_we   = 1'b1;
        mem_wd   = frame_byte(step_r, four, ret_r, ccr_r); // [RULE_17]
        if (step_r == slast) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_POP: begin
        mem_addr = sp_step[`MEM_AW-1:0];
        if (pop_ph_r && step_r == slast) begin
          st_nxt = ST_IDLE;
          sp_we  = 1'b1;
          sp_nxt = sp + flen; // [RULE_04]
        end
      end
      ST_MVRD: begin
        mem_addr = src[`MEM_AW-1:0]; // [RULE_12]
        st_nxt   = ST_MVWR;
      end
      ST_MVWR: begin
        mem_addr = dst[`MEM_AW-1:0]; // [RULE_12]
        mem_we   = 1'b1;
        mem_wd   = mem_rdata;
        mv_step  = 1'b1; // [RULE_13]
        // Stay busy until the last byte lands
        st_nxt   = (cnt == `CNT_LAST) ? ST_IDLE : ST_MVRD; // [RULE_14]
      end
      ST_SLEEP: begin
        if (wake) begin
          st_nxt = ST_IDLE; // [RULE_05]
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= ST_IDLE;
      exec_busy  <= 1'b0;
      sleep_req  <= 1'b0;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h00000000;
      op_r       <= `OP_NOP;
      cc_r       <= 4'h0;
      imm_r      <= 8'h00;
      ridx_r     <= 3'd0;
      ldc_reg_r  <= 1'b0;
      tgt_r      <= `PC_RST;
      pc_r       <= `PC_RST;
      ccr_r      <= `CCR_RST;
      ret_r      <= `PC_RST;
      newpc_r    <= `PC_RST;
      step_r     <= `STEP_ZERO;
      pop_ph_r   <= 1'b0;
      pop_buf_r  <= 32'h00000000;
      taken_r    <= 1'b0;
      mem_addr_r <= {`MEM_AW{1'b0}};
    end else begin
      state_r   <= st_nxt;
      exec_busy <= (st_nxt != ST_IDLE); // [RULE_14]
      sleep_req <= (st_nxt == ST_SLEEP); // [RULE_05]
      // One wait state on every transfer gives the byte memory time to answer
      pready    <= apb_acc & ~pready;
      if (apb_acc && !pready) begin
        prdata  <= rd_data;
        pslverr <= refuse;
      end
      if (issue) begin
        op_r      <= pwdata[`F_OP];
        cc_r      <= pwdata[`F_CC];
        imm_r     <= pwdata[`F_IMM];
        ridx_r    <= pwdata[`F_RIDX];
        ldc_reg_r <= pwdata[`F_LDCREG];
        step_r    <= `STEP_ZERO;
        pop_ph_r  <= 1'b0;
      end
      if (wr_ev && idle) begin
        case (paddr)
          `A_TARGET:  tgt_r      <= pwdata[15:0];
          `A_PC:      pc_r       <= pwdata[15:0];
          `A_CCR:     ccr_r      <= pwdata[7:0];
          `A_MEMADDR: mem_addr_r <= pwdata[`MEM_AW-1:0];
          default:    ;
        endcase
      end
      case (state_r)
        ST_EXEC: begin
          case (op_r)
            `OP_BCC: begin
              taken_r <= cond_true(cc_r, ccr_r); // [RULE_01]
              pc_r    <= cond_true(cc_r, ccr_r) ? nxt_pc + tgt_r : nxt_pc; // [RULE_16]
            end
            `OP_JMP:  pc_r <= tgt_r; // [RULE_02]
            `OP_JSR: begin
              ret_r   <= nxt_pc;
              newpc_r <= tgt_r;
            end
            `OP_BSR: begin
              ret_r   <= nxt_pc; // [RULE_03]
              newpc_r <= nxt_pc + tgt_r; // [RULE_03]
            end
            `OP_IRQ: begin
              ret_r   <= pc_r; // [RULE_17]
              newpc_r <= tgt_r;
            end
            `OP_LDC: begin
              ccr_r <= ldc_reg_r ? sel_gr[7:0] : imm_r; // [RULE_06]
              pc_r  <= nxt_pc;
            end
            `OP_FLAGS_AND_IMM: begin
              ccr_r <= ccr_r & imm_r; // [RULE_08]
              pc_r  <= nxt_pc;
            end
            `OP_ORC: begin
              ccr_r <= ccr_r | imm_r; // [RULE_09]
              pc_r  <= nxt_pc;
            end
            `OP_FLAGS_XOR_IMM: begin
              ccr_r <= ccr_r ^ imm_r; // [RULE_10]
              pc_r  <= nxt_pc;
            end
            `OP_MOVE: begin
              if (cnt == `CNT_ZERO) begin
                pc_r <= nxt_pc; // [RULE_13]
              end
            end
            `OP_RTE, `OP_RTS: ;
            default:  pc_r <= nxt_pc; // [RULE_11]
          endcase
        end
        ST_PUSH: begin
          step_r <= step_r + `STEP_ONE;
          if (step_r == slast) begin
            pc_r <= newpc_r;
          end
        end
        ST_POP: begin
          pop_ph_r <= ~pop_ph_r;
          if (pop_ph_r) begin
            pop_buf_r <= pop_w;
            step_r    <= step_r + `STEP_ONE;
            if (step_r == slast) begin
              pc_r <= pop_w[15:0]; // [RULE_04]
              if (four) begin
                ccr_r <= pop_w[31:24]; // [RULE_04]
              end
            end
          end
        end
        ST_MVWR: begin
          // Pointers wrap inside the byte memory; software keeps them in range
          if (cnt == `CNT_LAST) begin
            pc_r <= nxt_pc; // [RULE_14]
          end
        end
        default: ;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== exec_byte_ram.v
// Byte-wide data memory for stack frames and block moves.
// Single port, synchronous write, read data registered one cycle after address.
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.vh"

module exec_byte_ram (
  input  wire                clk,
  input  wire [`MEM_AW-1:0]  addr,
  input  wire                we,
  input  wire [7:0]          wdata,
  output reg  [7:0]          rdata
);

  reg [7:0] mem [0:`MEM_DEPTH-1];

  // Read-before-write: a write cycle returns the old byte
  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule
`default_nettype wire

// ===== exec_defs.vh
// Constants for the branch, flags and block move execution unit.
// Included by the unit, its byte memory and the bench; holds definitions only.
`ifndef EXEC_DEFS_VH
`define EXEC_DEFS_VH

`define APB_AW        8
`define MEM_AW        8
`define MEM_DEPTH     256

// APB register offsets (byte addresses)
`define A_INSTR       8'h00
`define A_TARGET      8'h04
`define A_PC          8'h08
`define A_CCR         8'h0C
`define A_STATUS      8'h10
`define A_MEMADDR     8'h14
`define A_MEMDATA     8'h18
// General registers sit at 0x20 + 4*n
`define A_GRWIN       7:5
`define A_GRIDX       4:2
`define A_ALIGN       1:0
`define GRWIN_VAL     3'b001

// Issue word fields
`define F_OP          3:0
`define F_CC          7:4
`define F_IMM         15:8
`define F_RIDX        18:16
`define F_LDCREG      19

// Status bits
`define ST_BUSY       0
`define ST_SLEEP      1
`define ST_TAKEN      2
`define ST_WAKE       0

// Operation codes
`define OP_NOP        4'h0
`define OP_BCC        4'h1
`define OP_JMP        4'h2
`define OP_JSR        4'h3
`define OP_BSR        4'h4
`define OP_RTE        4'h5
`define OP_RTS        4'h6
`define OP_SLEEP      4'h7
`define OP_LDC        4'h8
`define OP_STC        4'h9
`define OP_FLAGS_AND_IMM       4'hA
`define OP_ORC        4'hB
`define OP_FLAGS_XOR_IMM       4'hC
`define OP_MOVE       4'hD
`define OP_IRQ        4'hE

// Flag positions in the condition flags register
`define CCR_C         0
`define CCR_V         1
`define CCR_Z         2
`define CCR_N         3

// Fixed general register roles
`define GR_NUM        8
`define GR_CNT        3'd4
`define GR_SRC        3'd5
`define GR_DST        3'd6
`define GR_SP         3'd7

// Reset values and steps
`define PC_RST        16'h0000
`define CCR_RST       8'h00
`define GR_RST        16'h0000
`define PC_STEP       16'h0002
`define PTR_STEP      16'h0001
`define CNT_STEP      8'h01
`define CNT_LAST      8'h01
`define CNT_ZERO      8'h00
`define FRAME_LEN4    16'h0004
`define FRAME_LEN2    16'h0002
`define STEP_LAST4    2'd3
`define STEP_LAST2    2'd1
`define STEP_ZERO     2'd0
`define STEP_ONE      2'd1

`endif

// ===== exec_props.sv
// Checker for the execution unit, watching its APB and status ports only.
// Assumes the single pclk domain with asynchronous active-low presetn.
`timescale 1ns/1ps
`default_nettype none
module exec_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        wake_req,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sleep_req,
  input wire logic        exec_busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic done;
  logic issue;
  assign done  = psel && penable && pready;
  assign issue = done && pwrite && paddr == 8'h00 && !pslverr;
  property p_ready_wait; psel && !penable |=> !pready ##1 pready; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready late");
  property p_ready_pulse; pready |-> penable ##1 !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready stuck");
  property p_issue_busy; issue |=> exec_busy; endproperty
  a_issue_busy: assert property (p_issue_busy) else $error("no busy");
  // Busy on both ends of the transfer, so the write met a running instruction
  property p_refuse_busy;
    done && pwrite && paddr == 8'h00 && exec_busy && $past(exec_busy, 2) |-> pslverr;
  endproperty
  a_refuse_busy: assert property (p_refuse_busy) else $error("issue not refused");
  property p_short_op; issue && pwdata[3:0] <= 4'h2 |=> exec_busy ##1 !exec_busy; endproperty
  a_short_op: assert property (p_short_op) else $error("short op length");
  property p_flags_op;
    issue && pwdata[3:0] inside {[4'h8:4'hC]} |=> exec_busy ##1 !exec_busy;
  endproperty
  a_flags_op: assert property (p_flags_op) else $error("flag op length");
  property p_sleep_enter; issue && pwdata[3:0] == 4'h7 && !wake_req |-> ##[1:3] sleep_req; endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("no sleep");
  property p_sleep_busy; sleep_req |-> exec_busy; endproperty
  a_sleep_busy: assert property (p_sleep_busy) else $error("sleep not busy");
  property p_wake; sleep_req && wake_req |-> ##[1:3] !sleep_req; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  c_move: cover property (issue && pwdata[3:0] == 4'hD);
  c_wake: cover property (sleep_req && wake_req);
  c_refused: cover property (done && pslverr);
endmodule
`default_nettype wire

// ===== tb.sv
// Bench for the execution unit: APB tasks issue instructions and read back state.
// Assumes a 10 MHz pclk and the unit's own register map.
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.vh"
module tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        wake_req;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sleep_req;
  logic        exec_busy;
  logic [31:0] r;
  logic        e;
  int          miscompares;
  int          n_tests;
  logic [31:0] fw [5] = '{32'h0000A50A, 32'h0000810B, 32'h0000FF0C, 32'h00001108, 32'h000A0008};
  logic [31:0] fx [5] = '{32'h24, 32'hA5, 32'h5A, 32'h11, 32'hC3};
  branch_sysctl_blockmove_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .wake_req(wake_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req),
    .exec_busy(exec_busy));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  // Holds the request until pready is sampled high; only the watchdog ends a hung wait
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(a, 1'b0, 32'h0);
    chk(r, x);
  endtask
  task automatic idle;
    int k;
    k = 0;
    do begin
      apb(`A_STATUS, 1'b0, 32'h0);
      k++;
    end while (r[`ST_BUSY] !== 1'b0 && k < 100);
    if (k >= 100) miscompares++;
  endtask
  task automatic iss(input logic [31:0] w);
    wr(`A_INSTR, w);
    idle;
  endtask
  task automatic setm(input logic [7:0] a, input logic [31:0] d);
    wr(`A_MEMADDR, {24'h0, a});
    wr(`A_MEMDATA, d);
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] x);
    wr(`A_MEMADDR, {24'h0, a});
    rdc(`A_MEMDATA, x);
  endtask
  function automatic logic taken(input logic [3:0] cc, input logic [3:0] f);
    logic c;
    logic v;
    logic z;
    logic m;
    logic [7:0] t;
    c = f[`CCR_C];
    v = f[`CCR_V];
    z = f[`CCR_Z];
    m = f[`CCR_N];
    t = {z | (m ^ v), m ^ v, m, v, z, c, c | z, 1'b0};
    return cc[0] ? t[cc[3:1]] : !t[cc[3:1]];
  endfunction
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // About 8k cycles are needed; 30k leaves room for slow answers
  initial begin
    #3000000;
    miscompares++;
    wrap_up;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    wake_req = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`A_PC, 32'h0);
    rdc(8'h1C, 32'h0);
    chk({31'h0, e}, 32'h1);
    for (int cc = 0; cc < 16; cc++) begin
      for (int f = 0; f < 16; f++) begin
        wr(`A_CCR, f);
        wr(`A_PC, 32'h0100);
        wr(`A_TARGET, 32'h0010);
        iss({24'h0, 4'(cc), `OP_BCC});
        chk({31'h0, r[`ST_TAKEN]}, {31'h0, taken(4'(cc), 4'(f))});
        rdc(`A_PC, taken(4'(cc), 4'(f)) ? 32'h0112 : 32'h0102);
        rdc(`A_CCR, f);
      end
    end
    $display("branch conditions end");
    wr(`A_CCR, 32'h0F);
    wr(`A_TARGET, 32'h1234);
    iss(`OP_JMP);
    rdc(`A_PC, 32'h1234);
    rdc(`A_CCR, 32'h0F);
    wr(8'h3C, 32'h0080);
    wr(`A_PC, 32'h0200);
    wr(`A_TARGET, 32'h0020);
    iss(`OP_BSR);
    rdc(`A_PC, 32'h0222);
    rdc(8'h3C, 32'h007E);
    rdm(8'h7F, 32'h02);
    wr(`A_CCR, 32'h5A);
    wr(`A_TARGET, 32'h0300);
    iss(`OP_IRQ);
    rdc(`A_PC, 32'h0300);
    rdm(8'h7A, 32'h5A);
    rdm(8'h7D, 32'h22);
    wr(`A_CCR, 32'h00);
    iss(`OP_RTE);
    rdc(`A_PC, 32'h0222);
    rdc(`A_CCR, 32'h5A);
    rdc(8'h3C, 32'h007E);
    wr(`A_TARGET, 32'h0500);
    iss(`OP_JSR);
    rdc(`A_PC, 32'h0500);
    rdc(8'h3C, 32'h007C);
    rdm(8'h7D, 32'h24);
    iss(`OP_RTS);
    rdc(`A_PC, 32'h0224);
    rdc(8'h3C, 32'h007E);
    rdc(`A_CCR, 32'h5A);
    $display("jump call return end");
    wr(`A_CCR, 32'h3C);
    wr(8'h28, 32'h00C3);
    for (int i = 0; i < 5; i++) begin
      iss(fw[i]);
      rdc(`A_CCR, fx[i]);
    end
    iss(32'h00030009);
    apb(8'h2C, 1'b0, 32'h0);
    chk({24'h0, r[7:0]}, 32'hC3);
    wr(`A_PC, 32'h0400);
    iss(`OP_NOP);
    rdc(`A_PC, 32'h0402);
    rdc(`A_CCR, 32'hC3);
    $display("flag ops end");
    wr(`A_INSTR, `OP_SLEEP);
    apb(`A_STATUS, 1'b0, 32'h0);
    chk({30'h0, r[1:0]}, 32'h3);
    wr(`A_INSTR, `OP_NOP);
    chk({31'h0, e}, 32'h1);
    @(posedge pclk);
    wake_req <= 1'b1;
    @(posedge pclk);
    wake_req <= 1'b0;
    idle;
    rdc(`A_PC, 32'h0404);
    wr(`A_INSTR, `OP_SLEEP);
    wr(`A_STATUS, 32'h1);
    idle;
    rdc(`A_PC, 32'h0406);
    $display("sleep end");
    for (int i = 0; i < 4; i++) begin
      setm(8'h10 + 8'(i), 32'hA0 + 32'(i));
      setm(8'h40 + 8'(i), 32'h55);
    end
    wr(8'h30, 32'h0303);
    wr(8'h34, 32'h0010);
    wr(8'h38, 32'h0040);
    wr(`A_INSTR, `OP_MOVE);
    wr(`A_PC, 32'h0);
    chk({31'h0, e}, 32'h1);
    idle;
    for (int i = 0; i < 3; i++) rdm(8'h40 + 8'(i), 32'hA0 + 32'(i));
    rdm(8'h43, 32'h55);
    rdc(8'h30, 32'h0300);
    rdc(8'h34, 32'h0013);
    rdc(8'h38, 32'h0043);
    rdc(`A_PC, 32'h0408);
    iss(`OP_MOVE);
    rdc(`A_PC, 32'h040A);
    rdc(8'h38, 32'h0043);
    $display("block move end");
    wrap_up;
  end
endmodule
bind branch_sysctl_blockmove_exec exec_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .wake_req(wake_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sleep_req(sleep_req), .exec_busy(exec_busy));
`default_nettype wire
